/* rtl/phy_status_pkg.sv */
package phy_status_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SUMMARY = 8'h10;
   localparam logic [7:0] IDX_FALSE_CARRIER = 8'h14;
   localparam logic [7:0] IDX_RX_ERROR = 8'h15;
   localparam logic [7:0] IDX_TENBASE = 8'h18;
   localparam logic [7:0] IDX_PHY_CONTROL = 8'h19;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1D;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1E;
   // summary register fields
   localparam int SUM_RESERVED_BIT = 15;
   localparam int SUM_CROSSOVER_BIT = 14;
   localparam int SUM_RX_ERROR_BIT = 13;
   localparam int SUM_POLARITY_BIT = 12;
   localparam int SUM_FALSE_CARRIER_BIT = 11;
   // tenbase status field
   localparam int TENBASE_POLARITY_BIT = 4;
   // control fields
   localparam int CTRL_AUTO_ENABLE_BIT = 15;
   localparam int CTRL_FORCE_BIT = 14;
   localparam logic [15:0] CTRL_RESET = 16'h8000;
   // interrupt status layout
   localparam int IRQ_RX_ERROR_BIT = 0;
   localparam int IRQ_FALSE_CARRIER_BIT = 1;
   localparam int IRQ_POLARITY_BIT = 2;
   localparam int IRQ_CROSSOVER_BIT = 3;
   localparam int IRQ_WIDTH = 4;
   // synchronised input lanes
   localparam int LANE_RX_ERROR = 0;
   localparam int LANE_FALSE_CARRIER = 1;
   localparam int LANE_POLARITY = 2;
   localparam int LANE_SWAPPED = 3;
   localparam int LANE_COUNT = 4;
   localparam int COUNT_WIDTH = 16;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

/* rtl/phy_status_summary_upper_bits.sv */
`timescale 1ns/1ps
// Functional notes
// R1: summary status register sits at management index 0x10.
// R2: bit 15 reserved, writes ignored, always reads zero.
// R3: bit 14 reads 1 when pairs swapped, 0 when normal.
// R4: bit 14 follows auto enable and force; tracks algorithm when auto and not forced.
// R5: bit 13 latches on receive error until error counter read.
// R6: receive error latch clears on counter read at 0x15, not summary.
// R7: bit 12 mirrors tenbase status bit 4, inverted polarity seen.
// R8: polarity bit clears on tenbase status read, not summary read.
// R9: bit 11 latches on false carrier until its counter is read.
// R10: false carrier latch clears on counter read at 0x14.
// R11: bits 15 to 11 read zero after reset until an event.
// R12: writes to the summary register change nothing.
module phy_status_summary_upper_bits (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_error_pin,
   input wire logic false_carrier_pin,
   input wire logic polarity_inverted_pin,
   input wire logic crossover_alg_swapped_pin,
   output logic pairs_swapped,
   output logic irq
);
   localparam int CW = phy_status_pkg::COUNT_WIDTH;
   localparam int IW = phy_status_pkg::IRQ_WIDTH;

   pin_sync_if #(.WIDTH(phy_status_pkg::LANE_COUNT)) syn ();

   logic [phy_status_pkg::LANE_COUNT-1:0] pin_vec;
   assign pin_vec[phy_status_pkg::LANE_RX_ERROR] = rx_error_pin;
   assign pin_vec[phy_status_pkg::LANE_FALSE_CARRIER] = false_carrier_pin;
   assign pin_vec[phy_status_pkg::LANE_POLARITY] = polarity_inverted_pin;
   assign pin_vec[phy_status_pkg::LANE_SWAPPED] =
      crossover_alg_swapped_pin;

   pin_sync #(.WIDTH(phy_status_pkg::LANE_COUNT)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(pin_vec),
      .out(syn.source)
   );

   logic rx_error_ev;
   logic false_carrier_ev;
   logic polarity_level;
   logic alg_swapped;
   assign rx_error_ev = syn.rise[phy_status_pkg::LANE_RX_ERROR];
   assign false_carrier_ev = syn.rise[phy_status_pkg::LANE_FALSE_CARRIER];
   assign polarity_level = syn.level[phy_status_pkg::LANE_POLARITY];
   assign alg_swapped = syn.level[phy_status_pkg::LANE_SWAPPED];

   // write channel
   logic aw_held_reg;
   logic [7:0] aw_idx_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic wr_fire;
   logic [7:0] wr_idx;
   logic wr_mapped;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_idx = aw_idx_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_idx_reg <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_comb begin
      unique case (wr_idx)
         phy_status_pkg::IDX_SUMMARY,
         phy_status_pkg::IDX_FALSE_CARRIER,
         phy_status_pkg::IDX_RX_ERROR,
         phy_status_pkg::IDX_TENBASE,
         phy_status_pkg::IDX_PHY_CONTROL,
         phy_status_pkg::IDX_IRQ_STATUS,
         phy_status_pkg::IDX_IRQ_CLEAR,
         phy_status_pkg::IDX_IRQ_ENABLE: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= phy_status_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? phy_status_pkg::RESP_OKAY
                                : phy_status_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // per-register write helpers
   logic ctrl_wr;
   logic irq_clear_wr;
   logic irq_enable_wr;
   assign ctrl_wr = wr_fire && wr_idx == phy_status_pkg::IDX_PHY_CONTROL;
   assign irq_clear_wr = wr_fire && wr_idx == phy_status_pkg::IDX_IRQ_CLEAR;
   assign irq_enable_wr =
      wr_fire && wr_idx == phy_status_pkg::IDX_IRQ_ENABLE;

   // control register
   logic [15:0] ctrl_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= phy_status_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         if (w_strb_reg[0]) begin
            ctrl_reg[7:0] <= w_data_reg[7:0];
         end
         if (w_strb_reg[1]) begin
            ctrl_reg[15:8] <= w_data_reg[15:8];
         end
      end
   end

   logic auto_enable;
   logic force_swap;
   assign auto_enable = ctrl_reg[phy_status_pkg::CTRL_AUTO_ENABLE_BIT];
   assign force_swap = ctrl_reg[phy_status_pkg::CTRL_FORCE_BIT];

   // read channel
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic rd_fire;
   logic [7:0] rd_idx;
   assign s_axi_arready = !rvalid_reg;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_idx = s_axi_araddr[9:2];

   // read side effects fire on the address handshake
   logic rd_rx_error_cnt;
   logic rd_false_carrier_cnt;
   logic rd_tenbase;
   // R6: clear on 0x15
   assign rd_rx_error_cnt = rd_fire && rd_idx == phy_status_pkg::IDX_RX_ERROR;
   // R10: clear on 0x14
   assign rd_false_carrier_cnt =
      rd_fire && rd_idx == phy_status_pkg::IDX_FALSE_CARRIER;
   // R8: clear on tenbase read
   assign rd_tenbase = rd_fire && rd_idx == phy_status_pkg::IDX_TENBASE;

   // status latches and counters
   logic crossover_reg;
   logic rx_error_latch_reg;
   logic false_carrier_latch_reg;
   logic polarity_reg;
   logic [CW-1:0] rx_error_cnt_reg;
   logic [CW-1:0] false_carrier_cnt_reg;

   // R4: force wins, then auto tracks the algorithm
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // R11: zero after reset
         crossover_reg <= 1'b0;
      end else if (force_swap) begin
         crossover_reg <= 1'b1;
      end else if (auto_enable) begin
         crossover_reg <= alg_swapped;
      end else begin
         crossover_reg <= 1'b0;
      end
   end
   // R3: swapped pairs drive
   assign pairs_swapped = crossover_reg;

   // R5: latch receive error, set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_error_latch_reg <= 1'b0;
      end else if (rx_error_ev) begin
         rx_error_latch_reg <= 1'b1;
      end else if (rd_rx_error_cnt) begin
         rx_error_latch_reg <= 1'b0;
      end
   end

   // R9: latch false carrier, set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         false_carrier_latch_reg <= 1'b0;
      end else if (false_carrier_ev) begin
         false_carrier_latch_reg <= 1'b1;
      end else if (rd_false_carrier_cnt) begin
         false_carrier_latch_reg <= 1'b0;
      end
   end

   // R7: polarity latch shared with tenbase bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         polarity_reg <= 1'b0;
      end else if (polarity_level) begin
         polarity_reg <= 1'b1;
      end else if (rd_tenbase) begin
         polarity_reg <= 1'b0;
      end
   end

   // counters saturate so a long run of events never wraps to a small value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_error_cnt_reg <= '0;
      end else if (rd_rx_error_cnt) begin
         rx_error_cnt_reg <= rx_error_ev ? CW'(1) : '0;
      end else if (rx_error_ev && !(&rx_error_cnt_reg)) begin
         rx_error_cnt_reg <= rx_error_cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         false_carrier_cnt_reg <= '0;
      end else if (rd_false_carrier_cnt) begin
         false_carrier_cnt_reg <= false_carrier_ev ? CW'(1) : '0;
      end else if (false_carrier_ev && !(&false_carrier_cnt_reg)) begin
         false_carrier_cnt_reg <= false_carrier_cnt_reg + CW'(1);
      end
   end

   // interrupt
   logic [IW-1:0] irq_status_reg;
   logic [IW-1:0] irq_enable_reg;
   logic [IW-1:0] irq_events;
   logic crossover_prev_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crossover_prev_reg <= 1'b0;
      end else begin
         crossover_prev_reg <= crossover_reg;
      end
   end

   always_comb begin
      irq_events = '0;
      irq_events[phy_status_pkg::IRQ_RX_ERROR_BIT] = rx_error_ev;
      irq_events[phy_status_pkg::IRQ_FALSE_CARRIER_BIT] = false_carrier_ev;
      irq_events[phy_status_pkg::IRQ_POLARITY_BIT] =
         polarity_level && !polarity_reg;
      irq_events[phy_status_pkg::IRQ_CROSSOVER_BIT] =
         crossover_reg ^ crossover_prev_reg;
   end

   // an event in the clearing cycle stays set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= '0;
      end else if (irq_clear_wr) begin
         irq_status_reg <= (irq_status_reg & ~w_data_reg[IW-1:0])
                           | irq_events;
      end else begin
         irq_status_reg <= irq_status_reg | irq_events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable_reg <= '0;
      end else if (irq_enable_wr && w_strb_reg[0]) begin
         irq_enable_reg <= w_data_reg[IW-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // read data
   logic [15:0] summary_word;
   always_comb begin
      summary_word = 16'h0000;
      // R2: reserved reads zero
      summary_word[phy_status_pkg::SUM_RESERVED_BIT] = 1'b0;
      // R3: crossover state
      summary_word[phy_status_pkg::SUM_CROSSOVER_BIT] = crossover_reg;
      summary_word[phy_status_pkg::SUM_RX_ERROR_BIT] = rx_error_latch_reg;
      // R7: mirror of polarity
      summary_word[phy_status_pkg::SUM_POLARITY_BIT] = polarity_reg;
      summary_word[phy_status_pkg::SUM_FALSE_CARRIER_BIT] =
         false_carrier_latch_reg;
   end

   logic [15:0] tenbase_word;
   always_comb begin
      tenbase_word = 16'h0000;
      tenbase_word[phy_status_pkg::TENBASE_POLARITY_BIT] = polarity_reg;
   end

   logic [31:0] rd_word;
   logic rd_mapped;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_mapped = 1'b1;
      unique case (rd_idx)
         // R1: summary at 0x10
         phy_status_pkg::IDX_SUMMARY: rd_word[15:0] = summary_word;
         phy_status_pkg::IDX_FALSE_CARRIER: rd_word[CW-1:0] =
            false_carrier_cnt_reg;
         phy_status_pkg::IDX_RX_ERROR: rd_word[CW-1:0] = rx_error_cnt_reg;
         phy_status_pkg::IDX_TENBASE: rd_word[15:0] = tenbase_word;
         phy_status_pkg::IDX_PHY_CONTROL: rd_word[15:0] = ctrl_reg;
         phy_status_pkg::IDX_IRQ_STATUS: rd_word[IW-1:0] = irq_status_reg;
         phy_status_pkg::IDX_IRQ_CLEAR: rd_word = 32'h0000_0000;
         phy_status_pkg::IDX_IRQ_ENABLE: rd_word[IW-1:0] = irq_enable_reg;
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= phy_status_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_mapped ? phy_status_pkg::RESP_OKAY
                                : phy_status_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // R12: no write path reaches the summary, counters or tenbase word;
   // such writes complete with OKAY and change nothing
endmodule // phy_status_summary_upper_bits

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pins,
   pin_sync_if.source out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   // first stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign out.level = sync_reg;
   assign out.rise = sync_reg & ~prev_reg;
endmodule // pin_sync

/* rtl/pin_sync_if.sv */
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 4);
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] rise;
   modport source (output level, output rise);
   modport sink (input level, input rise);
endinterface // pin_sync_if

/* sim/phy_line_model.sv */
`timescale 1ns/1ps
module phy_line_model (
   input wire logic aclk,
   output logic rx_error_pin,
   output logic false_carrier_pin,
   output logic polarity_inverted_pin,
   output logic crossover_alg_swapped_pin
);
   logic [3:0] lane_q = 4'h0;
   assign rx_error_pin = lane_q[phy_status_pkg::LANE_RX_ERROR];
   assign false_carrier_pin = lane_q[phy_status_pkg::LANE_FALSE_CARRIER];
   assign polarity_inverted_pin = lane_q[phy_status_pkg::LANE_POLARITY];
   assign crossover_alg_swapped_pin = lane_q[phy_status_pkg::LANE_SWAPPED];
   // two edges high so the pin synchroniser cannot miss an event
   task automatic pulse(input int lane);
      @(posedge aclk);
      lane_q[lane] <= 1'b1;
      repeat (2) @(posedge aclk);
      lane_q[lane] <= 1'b0;
   endtask
   task automatic level(input int lane, input logic v);
      @(posedge aclk);
      lane_q[lane] <= v;
   endtask
endmodule // phy_line_model

/* sim/phy_status_checker.sv */
`timescale 1ns/1ps
module phy_status_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic pairs_swapped,
   input wire logic irq
);
   localparam logic [31:0] SUM_A = 32'h40;
   logic [31:0] rd_q;
   logic [31:0] wr_q;
   logic rv_q;
   logic [2:0] keep_q;
   logic new_sum;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready)
         rd_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready)
         wr_q <= s_axi_awaddr;
      rv_q <= s_axi_rvalid;
   end
   assign new_sum = s_axi_rvalid && !rv_q && rd_q == SUM_A;
   // a latch once seen set may only drop by its own clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         keep_q <= 3'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         if (s_axi_araddr == 32'h54) keep_q[2] <= 1'b0;
         if (s_axi_araddr == 32'h60) keep_q[1] <= 1'b0;
         if (s_axi_araddr == 32'h50) keep_q[0] <= 1'b0;
      end else if (new_sum) begin
         keep_q <= keep_q | s_axi_rdata[13:11];
      end
   end
   a_reset_quiet: assert property (
      $rose(aresetn) |-> !irq && !pairs_swapped && !s_axi_rvalid
         && !s_axi_bvalid && s_axi_arready)
      else $error("outputs not idle after reset");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_write_okay: assert property (
      s_axi_bvalid && wr_q == SUM_A |-> s_axi_bresp == 2'h0)
      else $error("summary write not accepted");
   a_rsvd_zero: assert property (
      new_sum |-> !s_axi_rdata[15])
      else $error("reserved bit set");
   a_crossover_bit: assert property (
      new_sum |-> s_axi_rdata[14] == $past(pairs_swapped))
      else $error("crossover bit differs from pin");
   a_rx_sticky: assert property (
      new_sum && keep_q[2] |-> s_axi_rdata[13])
      else $error("rx error latch lost");
   a_pol_sticky: assert property (
      new_sum && keep_q[1] |-> s_axi_rdata[12])
      else $error("polarity latch lost");
   a_fc_sticky: assert property (
      new_sum && keep_q[0] |-> s_axi_rdata[11])
      else $error("false carrier latch lost");
   c_rx_seen: cover property (new_sum && s_axi_rdata[13]);
   c_swapped: cover property ($rose(pairs_swapped));
   c_irq: cover property ($rose(irq));
endmodule // phy_status_checker
bind phy_status_summary_upper_bits phy_status_checker i_chk (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .pairs_swapped, .irq
);

/* sim/phy_status_summary_upper_bits_test.sv */
`timescale 1ns/1ps
module phy_status_summary_upper_bits_test;
   localparam logic [31:0] SUM_A = 32'h40;
   localparam logic [31:0] FC_A = 32'h50;
   localparam logic [31:0] RE_A = 32'h54;
   localparam logic [31:0] TB_A = 32'h60;
   localparam logic [31:0] CT_A = 32'h64;
   localparam logic [31:0] IS_A = 32'h70;
   localparam logic [31:0] IC_A = 32'h74;
   localparam logic [31:0] IE_A = 32'h78;
   localparam logic [1:0] OK = 2'h0;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, pairs_swapped, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rx_error_pin, false_carrier_pin, polarity_inverted_pin;
   logic crossover_alg_swapped_pin;
   int err_count, checked;
   phy_status_summary_upper_bits i_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rx_error_pin, .false_carrier_pin, .polarity_inverted_pin,
      .crossover_alg_swapped_pin, .pairs_swapped, .irq);
   phy_line_model i_line (.aclk, .rx_error_pin, .false_carrier_pin,
      .polarity_inverted_pin, .crossover_alg_swapped_pin);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic guard(input logic got);
      if (!got) begin
         err_count++;
         test_done();
      end
   endtask
   // requests change after an edge; answers are taken at the edge they stand
   task automatic wc(input logic [31:0] a, input logic [31:0] d,
         input logic [1:0] r);
      logic got;
      logic [1:0] resp;
      got = 1'b0;
      resp = 2'h0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 50 && !got; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            got = 1'b1;
            resp = s_axi_bresp;
         end
      end
      guard(got);
      chk({32'h0, resp}, {32'h0, r});
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] d,
         input logic [1:0] r);
      logic got;
      logic [33:0] seen;
      got = 1'b0;
      seen = '0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 50 && !got; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            got = 1'b1;
            seen = {s_axi_rresp, s_axi_rdata};
         end
      end
      guard(got);
      chk(seen, {r, d});
   endtask
   // pins need two edges through the synchroniser
   task automatic settle;
      repeat (5) @(posedge aclk);
   endtask
   task automatic look(input logic sw, input logic iq);
      @(negedge aclk);
      chk({32'h0, pairs_swapped, irq}, {32'h0, sw, iq});
      @(posedge aclk);
   endtask
   initial begin
      logic [31:0] ctl [6];
      logic [5:0] pinv, expv;
      ctl = '{32'h8000, 32'h8000, 32'h4000, 32'h0, 32'hC000, 32'h8000};
      pinv = 6'b001001;
      expv = 6'b010101;
      err_count = 0;
      checked = 0;
      aresetn <= 1'b0;
      s_axi_awaddr <= 32'h0;
      s_axi_awvalid <= 1'b0;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      s_axi_araddr <= 32'h0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      look(1'b0, 1'b0);
      rc(SUM_A, 32'h0, OK);
      rc(CT_A, 32'h8000, OK);
      rc(IE_A, 32'h0, OK);
      wc(SUM_A, 32'hFFFF, OK);
      rc(SUM_A, 32'h0, OK);
      rc(32'h3FC, 32'h0, 2'h3);
      for (int i = 0; i < 6; i++) begin
         wc(CT_A, ctl[i], OK);
         i_line.level(phy_status_pkg::LANE_SWAPPED, pinv[i]);
         settle();
         rc(SUM_A, {17'h0, expv[i], 14'h0}, OK);
         look(expv[i], 1'b0);
      end
      i_line.pulse(phy_status_pkg::LANE_RX_ERROR);
      i_line.pulse(phy_status_pkg::LANE_FALSE_CARRIER);
      i_line.pulse(phy_status_pkg::LANE_RX_ERROR);
      settle();
      rc(SUM_A, 32'h2800, OK);
      rc(SUM_A, 32'h2800, OK);
      rc(FC_A, 32'h1, OK);
      rc(SUM_A, 32'h2000, OK);
      rc(RE_A, 32'h2, OK);
      rc(SUM_A, 32'h0, OK);
      i_line.level(phy_status_pkg::LANE_POLARITY, 1'b1);
      settle();
      rc(SUM_A, 32'h1000, OK);
      rc(TB_A, 32'h10, OK);
      i_line.level(phy_status_pkg::LANE_POLARITY, 1'b0);
      settle();
      rc(SUM_A, 32'h1000, OK);
      rc(SUM_A, 32'h1000, OK);
      rc(TB_A, 32'h10, OK);
      rc(SUM_A, 32'h0, OK);
      rc(IS_A, 32'hF, OK);
      wc(IC_A, 32'hF, OK);
      rc(IS_A, 32'h0, OK);
      rc(IC_A, 32'h0, OK);
      wc(IE_A, 32'h1, OK);
      i_line.pulse(phy_status_pkg::LANE_FALSE_CARRIER);
      settle();
      look(1'b0, 1'b0);
      rc(IS_A, 32'h2, OK);
      i_line.pulse(phy_status_pkg::LANE_RX_ERROR);
      settle();
      look(1'b0, 1'b1);
      wc(IC_A, 32'h1, OK);
      look(1'b0, 1'b0);
      i_line.pulse(phy_status_pkg::LANE_RX_ERROR);
      settle();
      look(1'b0, 1'b1);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      look(1'b0, 1'b0);
      rc(SUM_A, 32'h0, OK);
      rc(IE_A, 32'h0, OK);
      rc(CT_A, 32'h8000, OK);
      test_done();
   end
endmodule // phy_status_summary_upper_bits_test
